/* hdl/packed_decimal_codec.sv */
// packed decimal codec: digit checks, decimal load and store
`timescale 1ns/1ps
`default_nettype none
module packed_decimal_codec (
    input wire logic clk_sys,
    input wire logic reset_n,
    // general-purpose byte check
    input wire logic [7:0] gprByte,
    input wire logic gprPacked,
    input wire logic gprMulDiv,
    output logic [7:0] gprDigit,
    output logic gprBad,
    // decimal load
    input wire logic loadStart,
    input wire logic [79:0] loadDecimal,
    output logic [79:0] loadExtended,
    output logic loadInvalid,
    output logic loadDone,
    output logic loadBusy,
    // decimal store
    input wire logic storeStart,
    input wire logic [63:0] storeMagnitude,
    input wire logic storeSign,
    input wire logic storeInvalid,
    input wire logic invalidMasked,
    output logic [79:0] storeDecimal,
    output logic storeWrite,
    output logic storeFault
);
    // ------------------------------------------------------------
    // byte digit check
    // ------------------------------------------------------------
    logic [7:0] unitDigit;
    logic unitBad;
    logic [7:0] gprDigit_ff;
    logic gprBad_ff;
    logic [7:0] nxt_gprDigit;
    logic nxt_gprBad;

    pdc_digit_unit uDigit (
        .byteIn(gprByte),
        .packedMode(gprPacked),
        .mulDivOp(gprMulDiv),
        .digitVal(unitDigit),
        .byteBad(unitBad)
    );

    always_comb begin
        nxt_gprDigit = unitDigit;
        nxt_gprBad = unitBad;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            gprDigit_ff <= 8'h00;
            gprBad_ff <= 1'b0;
        end else begin
            gprDigit_ff <= nxt_gprDigit;
            gprBad_ff <= nxt_gprBad;
        end
    end
    assign gprDigit = gprDigit_ff;
    assign gprBad = gprBad_ff;

    // ------------------------------------------------------------
    // decimal load: one digit per cycle, then normalise
    // ------------------------------------------------------------
    pdc_pkg::pdc_state_t state_ff;
    pdc_pkg::pdc_state_t nxt_state;
    logic [71:0] digits_ff;
    logic [71:0] nxt_digits;
    logic [63:0] acc_ff;
    logic [63:0] nxt_acc;
    logic [4:0] cnt_ff;
    logic [4:0] nxt_cnt;
    logic sign_ff;
    logic nxt_sign;
    logic bad_ff;
    logic nxt_bad;
    logic [79:0] ext_ff;
    logic [79:0] nxt_ext;
    logic done_ff;
    logic nxt_done;
    logic [3:0] topDigit;
    logic [5:0] lead;
    logic [63:0] shifted;

    assign topDigit = digits_ff[71:68];

    always_comb begin
        lead = 6'd0;
        for (int i = 0; i < 64; i++) begin
            if (acc_ff[i]) begin
                lead = 6'(63 - i);
            end
        end
        shifted = acc_ff << lead;
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_digits = digits_ff;
        nxt_acc = acc_ff;
        nxt_cnt = cnt_ff;
        nxt_sign = sign_ff;
        nxt_bad = bad_ff;
        nxt_ext = ext_ff;
        nxt_done = 1'b0;
        case (state_ff)
            pdc_pkg::PDC_IDLE: begin
                if (loadStart) begin
                    // bits 72..78 dropped on purpose
                    nxt_digits = loadDecimal[71:0];
                    nxt_sign = loadDecimal[pdc_pkg::SIGN_BIT];
                    nxt_acc = 64'h0000_0000_0000_0000;
                    nxt_cnt = pdc_pkg::CONV_CNT_RST;
                    nxt_bad = 1'b0;
                    nxt_state = pdc_pkg::PDC_LOAD;
                end
            end
            pdc_pkg::PDC_LOAD: begin
                // most significant digit first, from upper nibble of byte 8
                nxt_acc = 64'(acc_ff * 64'd10) + 64'(topDigit);
                nxt_bad = bad_ff | (topDigit > pdc_pkg::DIGIT_MAX);
                nxt_digits = {digits_ff[67:0], 4'h0};
                nxt_cnt = 5'(cnt_ff + 5'd1);
                if (cnt_ff == 5'(pdc_pkg::CONV_CYCLES - 1)) begin
                    nxt_state = pdc_pkg::PDC_NORM;
                end
            end
            pdc_pkg::PDC_NORM: begin
                // 10^18 < 2^64 so the conversion stays exact
                if (acc_ff == 64'h0000_0000_0000_0000) begin
                    nxt_ext = {sign_ff, 79'h0};
                end else begin
                    nxt_ext = {sign_ff,
                        15'(pdc_pkg::EXP_BIAS + 15'(6'd63 - lead)),
                        shifted};
                end
                nxt_state = pdc_pkg::PDC_DONE;
            end
            pdc_pkg::PDC_DONE: begin
                nxt_done = 1'b1;
                nxt_state = pdc_pkg::PDC_IDLE;
            end
            default: begin
                nxt_state = pdc_pkg::PDC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= pdc_pkg::PDC_IDLE;
            digits_ff <= 72'h0;
            acc_ff <= 64'h0000_0000_0000_0000;
            cnt_ff <= pdc_pkg::CONV_CNT_RST;
            sign_ff <= 1'b0;
            bad_ff <= 1'b0;
            ext_ff <= 80'h0;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            digits_ff <= nxt_digits;
            acc_ff <= nxt_acc;
            cnt_ff <= nxt_cnt;
            sign_ff <= nxt_sign;
            bad_ff <= nxt_bad;
            ext_ff <= nxt_ext;
            done_ff <= nxt_done;
        end
    end

    logic busy_ff;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= (nxt_state != pdc_pkg::PDC_IDLE);
        end
    end

    assign loadExtended = ext_ff;
    assign loadInvalid = bad_ff;
    assign loadDone = done_ff;
    assign loadBusy = busy_ff;

    // ------------------------------------------------------------
    // store: binary magnitude to decimal, one cycle
    // ------------------------------------------------------------
    logic [79:0] stDec_ff;
    logic [79:0] nxt_stDec;
    logic stWr_ff;
    logic nxt_stWr;
    logic stFault_ff;
    logic nxt_stFault;
    logic [71:0] bcd;
    logic tooBig;

    // double dabble; big combinational cone, traded for one-cycle latency
    always_comb begin
        bcd = 72'h0;
        for (int i = 63; i >= 0; i--) begin
            for (int d = 0; d < pdc_pkg::NUM_DIGITS; d++) begin
                if (bcd[d*4 +: 4] > 4'h4) begin
                    bcd[d*4 +: 4] = 4'(bcd[d*4 +: 4] + 4'h3);
                end
            end
            bcd = {bcd[70:0], storeMagnitude[i]};
        end
        tooBig = storeMagnitude > 64'h0DE0_B6B3_A763_FFFF;
    end

    always_comb begin
        nxt_stDec = stDec_ff;
        nxt_stWr = 1'b0;
        nxt_stFault = 1'b0;
        if (storeStart) begin
            if (storeInvalid | tooBig) begin
                if (invalidMasked) begin
                    nxt_stDec = pdc_pkg::DEC_INDEF;
                    nxt_stWr = 1'b1;
                end else begin
                    nxt_stFault = 1'b1;
                end
            end else begin
                nxt_stDec = {storeSign, 7'h00, bcd};
                nxt_stWr = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stDec_ff <= 80'h0;
            stWr_ff <= 1'b0;
            stFault_ff <= 1'b0;
        end else begin
            stDec_ff <= nxt_stDec;
            stWr_ff <= nxt_stWr;
            stFault_ff <= nxt_stFault;
        end
    end
    assign storeDecimal = stDec_ff;
    assign storeWrite = stWr_ff;
    assign storeFault = stFault_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_load_latency: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (loadStart && state_ff == pdc_pkg::PDC_IDLE) |-> ##21 loadDone)
        else $error("load done not 21 cycles after start");
    chk_indef_store: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (storeStart && storeInvalid && invalidMasked) |=>
        (storeWrite && storeDecimal == pdc_pkg::DEC_INDEF))
        else $error("indefinite not written");
    chk_unmasked_fault: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (storeStart && storeInvalid && !invalidMasked) |=>
        (storeFault && !storeWrite))
        else $error("unmasked invalid wrote memory");
    chk_store_sign: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (storeStart && !storeInvalid && !tooBig) |=>
        (storeDecimal[79] == $past(storeSign) &&
        storeDecimal[78:72] == 7'h00))
        else $error("stored sign wrong");
    chk_load_sign: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        loadDone |-> loadExtended[79] == sign_ff)
        else $error("load sign lost");
    chk_load_norm: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (loadDone && loadExtended[78:0] != 79'h0) |-> loadExtended[63])
        else $error("result not normalised");
    chk_bad_digit: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (state_ff == pdc_pkg::PDC_LOAD && topDigit > 4'h9) |=> loadInvalid)
        else $error("bad digit not flagged");
    chk_muldiv_high: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (!gprPacked && gprMulDiv && gprByte[7:4] != 4'h0) |=> gprBad)
        else $error("nonzero high nibble passed");
    chk_unpacked_val: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (!gprPacked) |=> gprDigit == {4'h0, $past(gprByte[3:0])})
        else $error("unpacked digit wrong");
    cov_load: cover property (@(posedge clk_sys) disable iff (!reset_n)
        loadDone);
    cov_indef: cover property (@(posedge clk_sys) disable iff (!reset_n)
        storeWrite && storeDecimal == pdc_pkg::DEC_INDEF);
    cov_bad: cover property (@(posedge clk_sys) disable iff (!reset_n)
        loadDone && loadInvalid);
endmodule : packed_decimal_codec
`default_nettype wire

/* hdl/pdc_digit_unit.sv */
// digit checker for unpacked and packed byte layouts
`timescale 1ns/1ps
`default_nettype none
module pdc_digit_unit (
    input wire logic [7:0] byteIn,
    input wire logic packedMode,
    input wire logic mulDivOp,
    output logic [7:0] digitVal,
    output logic byteBad
);
    logic loBad;
    logic hiBad;
    always_comb begin
        loBad = byteIn[3:0] > pdc_pkg::DIGIT_MAX;
        hiBad = byteIn[7:4] > pdc_pkg::DIGIT_MAX;
        if (packedMode) begin
            // high nibble outweighs low nibble
            digitVal = 8'(byteIn[7:4]) * 8'h0A + 8'(byteIn[3:0]);
            byteBad = loBad | hiBad;
        end else begin
            digitVal = {4'h0, byteIn[3:0]};
            // upper nibble free for add/sub, must be zero for mul/div
            byteBad = loBad | (mulDivOp & (byteIn[7:4] != 4'h0));
        end
    end
endmodule : pdc_digit_unit
`default_nettype wire

/* hdl/pdc_pkg.sv */
// package: constants and types for the packed decimal codec
package pdc_pkg;
    localparam int DIGIT_W = 4;
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam int NUM_DIGITS = 18;
    localparam int DEC_W = 80;
    localparam int SIGN_BIT = 79;
    localparam int EXT_W = 80;
    localparam int EXP_W = 15;
    localparam int MANT_W = 64;
    localparam logic [14:0] EXP_BIAS = 15'h3FFF;
    localparam logic [79:0] DEC_INDEF = 80'hFFFF_C000_0000_0000_0000;
    localparam int UNP_DIGIT_LO = 0;
    localparam int UNP_HIGH_LO = 4;
    localparam int CONV_CYCLES = 18;
    localparam logic [4:0] CONV_CNT_RST = 5'h00;

    typedef enum logic [1:0] {
        PDC_IDLE = 2'b00,
        PDC_LOAD = 2'b01,
        PDC_NORM = 2'b11,
        PDC_DONE = 2'b10
    } pdc_state_t;
endpackage : pdc_pkg

/* tb/pdc_fp_partner.sv */
// floating-point register side model that catches decimal load results
`timescale 1ns/1ps
`default_nettype none
module pdc_fp_partner (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic loadDone,
    input wire logic [79:0] loadExtended,
    input wire logic loadInvalid,
    output logic [79:0] fpReg,
    output logic fpInv
);
    // ----------------------------------------
    // destination register, ten byte image
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fpReg <= 80'h0000_0000_0000_0000_0000;
            fpInv <= 1'b0;
        end else if (loadDone) begin
            fpReg <= loadExtended;
            fpInv <= loadInvalid;
        end
    end
endmodule : pdc_fp_partner
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the packed decimal codec
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys = 1'b0, reset_n = 1'b0;
    logic [7:0] gprByte = 8'h00, gprDigit;
    logic gprPacked = 1'b0, gprMulDiv = 1'b0, gprBad;
    logic loadStart = 1'b0, loadInvalid, loadDone, loadBusy, fpInv;
    logic [79:0] loadDecimal = 80'h0, loadExtended, storeDecimal, fpReg;
    logic storeStart = 1'b0, storeSign = 1'b0, storeInvalid = 1'b0;
    logic invalidMasked = 1'b0, storeWrite, storeFault;
    logic [63:0] storeMagnitude = 64'h0;
    int numErrors = 0, testsRun = 0;
    localparam logic [63:0] MAXV = 64'h0DE0_B6B3_A763_FFFF;

    always #25 clk_sys = ~clk_sys;

    packed_decimal_codec i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .gprByte(gprByte), .gprPacked(gprPacked), .gprMulDiv(gprMulDiv),
        .gprDigit(gprDigit), .gprBad(gprBad), .loadStart(loadStart),
        .loadDecimal(loadDecimal), .loadExtended(loadExtended),
        .loadInvalid(loadInvalid), .loadDone(loadDone), .loadBusy(loadBusy),
        .storeStart(storeStart), .storeMagnitude(storeMagnitude),
        .storeSign(storeSign), .storeInvalid(storeInvalid),
        .invalidMasked(invalidMasked), .storeDecimal(storeDecimal),
        .storeWrite(storeWrite), .storeFault(storeFault));
    pdc_fp_partner i_fp (.clk_sys(clk_sys), .reset_n(reset_n),
        .loadDone(loadDone), .loadExtended(loadExtended),
        .loadInvalid(loadInvalid), .fpReg(fpReg), .fpInv(fpInv));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", testsRun, numErrors);
        if (numErrors == 0 && testsRun > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        testsRun++;
        if (seen !== exp) begin
            numErrors++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [79:0] decOf(input logic [63:0] v, input bit s);
        logic [79:0] d;
        d = '0;
        for (int i = 0; i < 18; i++) begin
            d[4*i+:4] = 4'(v % 10);
            v = v / 10;
        end
        d[79] = s;
        return d;
    endfunction : decOf

    function automatic logic [79:0] extOf(input logic [63:0] v, input bit s);
        int lz;
        lz = 0;
        if (v == 0) return {s, 79'h0};
        while (v[63] == 1'b0) begin
            v = v << 1;
            lz++;
        end
        return {s, 15'(16383 + 63 - lz), v};
    endfunction : extOf

    task automatic doGpr(input logic [7:0] b, input logic pk, input logic md,
                         input logic [7:0] dig, input logic bad);
        @(negedge clk_sys);
        gprByte = b;
        gprPacked = pk;
        gprMulDiv = md;
        @(negedge clk_sys);
        chk(80'(gprBad), 80'(bad));
        if (!bad) chk(80'(gprDigit), 80'(dig));
    endtask : doGpr

    task automatic doLoad(input logic [79:0] img, input logic [79:0] ext,
                          input logic inv);
        int n;
        @(negedge clk_sys);
        loadDecimal = img;
        loadStart = 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge clk_sys);
            loadStart = (n == 4); // refused while busy
            if (n == 0) chk(80'(loadBusy), 80'h1);
            if (loadDone === 1'b1) break;
        end
        chk(80'(n), 80'd20);
        if (n == 40) stop_test();
        @(negedge clk_sys);
        chk(80'(loadDone), 80'h0);
        chk(80'(fpInv), 80'(inv));
        if (!inv) chk(fpReg, ext);
    endtask : doLoad

    // starts at a negedge, leaves storeStart high for back-to-back use
    task automatic doStore(input logic [63:0] m, input logic s,
                           input logic iv, input logic mk,
                           input logic [79:0] img, input logic w);
        storeMagnitude = m;
        storeSign = s;
        storeInvalid = iv;
        invalidMasked = mk;
        storeStart = 1'b1;
        @(negedge clk_sys);
        chk(80'(storeWrite), 80'(w));
        chk(80'(storeFault), 80'(!w));
        if (w) chk(storeDecimal, img);
    endtask : doStore

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic testGpr();
        doGpr(8'h75, 1'b0, 1'b0, 8'h05, 1'b0);
        doGpr(8'h75, 1'b0, 1'b1, 8'h05, 1'b1);
        doGpr(8'h09, 1'b0, 1'b1, 8'h09, 1'b0);
        doGpr(8'h0A, 1'b0, 1'b0, 8'h00, 1'b1);
        doGpr(8'h93, 1'b1, 1'b0, 8'h5D, 1'b0);
        doGpr(8'hA3, 1'b1, 1'b0, 8'h00, 1'b1);
        doGpr(8'h3A, 1'b1, 1'b1, 8'h00, 1'b1);
    endtask : testGpr

    task automatic testLoad();
        // the indefinite pattern is never loaded on purpose
        doLoad(decOf(64'd1, 1'b0), extOf(64'd1, 1'b0), 1'b0);
        doLoad(decOf(64'd1, 1'b1) | {1'b0, 7'h55, 72'h0},
               extOf(64'd1, 1'b1), 1'b0);
        doLoad(decOf(MAXV, 1'b1), extOf(MAXV, 1'b1), 1'b0);
        doLoad(decOf(64'd0, 1'b0), 80'h0, 1'b0);
        doLoad(decOf(64'd5, 1'b0) | 80'h0_C000, 80'h0, 1'b1);
    endtask : testLoad

    task automatic testStore();
        @(negedge clk_sys);
        doStore(64'd123, 1'b1, 1'b0, 1'b0, decOf(64'd123, 1'b1),
                1'b1);
        doStore(64'd0, 1'b0, 1'b1, 1'b1, pdc_pkg::DEC_INDEF, 1'b1);
        doStore(64'd7, 1'b0, 1'b1, 1'b0, 80'h0, 1'b0);
        doStore(MAXV + 1, 1'b0, 1'b0, 1'b1, pdc_pkg::DEC_INDEF,
                1'b1);
        doStore(MAXV, 1'b0, 1'b0, 1'b0, decOf(MAXV, 1'b0), 1'b1);
        storeStart = 1'b0;
    endtask : testStore

    initial begin
        #1000000;
        numErrors++;
        stop_test();
    end

    initial begin
        repeat (6) @(negedge clk_sys);
        chk(80'({storeWrite, loadBusy, loadDone}), 80'h0);
        reset_n = 1'b1;
        testGpr();
        testLoad();
        testStore();
        stop_test();
    end
endmodule : tb
`default_nettype wire
